// [core/fepl_pkg.sv]
// Operation
// - Erase leaves cells reading one; write leaves cells reading zero.
// - Erase acts at once on all bits of every selected segment, never words.
// - Erase verify uses the erase-margin read mode with stricter condition.
// - A flash-write pulse acts on all bits of every selected segment at once.
// - Flash-write is selected only when write and erase requests are both high.
package fepl_pkg;

   // ==========================================
   // Timing
   localparam int unsigned CLK_HZ = 20_000_000;
   localparam int unsigned ERASE_PULSE_US = 5_000;
   localparam int unsigned WRITE_PULSE_US = 100;
   localparam int unsigned ERASE_PULSE_CYC = (ERASE_PULSE_US * (CLK_HZ / 1_000_000));
   localparam int unsigned WRITE_PULSE_CYC = (WRITE_PULSE_US * (CLK_HZ / 1_000_000));
   localparam int unsigned CNT_W = 24;

   // ==========================================
   // Array geometry
   localparam int unsigned SEG_N = 8;
   localparam int unsigned WORD_W = 16;
   localparam int unsigned MAX_WRITE_BITS = 8;

   // ==========================================
   // Operation modes
   typedef enum logic [1:0] {
      FEPL_OP_IDLE,
      FEPL_OP_WRITE,
      FEPL_OP_ERASE,
      FEPL_OP_FLASH_WRITE
   } fepl_op_t;

   // Request from the controlling core
   typedef struct packed {
      logic write_req;
      logic erase_req;
      logic execute_pulse_bit;
      logic erase_margin_read;
      logic program_margin_read;
      logic [SEG_N-1:0] seg_en;
      logic [WORD_W-1:0] wdata;
   } fepl_ctrl_t;

   // Drive toward the array and pump
   typedef struct packed {
      logic pump_write;
      logic pump_erase;
      logic erase_margin_read;
      logic program_margin_read;
      logic [SEG_N-1:0] seg_sel;
      logic [WORD_W-1:0] bit_mask;
   } fepl_array_t;

   localparam logic [SEG_N-1:0] SEG_RST = 8'h00;
   localparam logic [WORD_W-1:0] MASK_RST = 16'h0000;
   localparam logic [CNT_W-1:0] CNT_RST = 24'h000000;

endpackage : fepl_pkg

// [core/fepl_core.sv]
`timescale 1ns/1ps
module fepl_core
   import fepl_pkg::*;
(
   input wire logic clock,
   input wire logic rst_b,
   input wire fepl_ctrl_t ctrl,
   input wire logic mask_violation_ack,
   output fepl_array_t array_o,
   output logic pulse_busy_q,
   output logic pulse_done_q,
   output logic mask_error_q
);

   // ==========================================
   // Reset release
   logic rst_s1_b;
   logic rst_s2_b;

   // Reset synchroniser: asserts at once, releases after two edges
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         rst_s1_b <= 1'b0;
         rst_s2_b <= 1'b0;
      end else begin
         rst_s1_b <= 1'b1;
         rst_s2_b <= rst_s1_b;
      end
   end

   // ==========================================
   // Operation decode
   fepl_op_t op;
   logic [4:0] ones;

   // Write and erase together select flash-write
   always_comb begin
      ones = 5'h00;
      for (int i = 0; i < WORD_W; i++) begin
         ones = ones + {4'h0, ~ctrl.wdata[i]};
      end
      case ({ctrl.write_req, ctrl.erase_req})
         2'b10: op = FEPL_OP_WRITE;
         2'b01: op = FEPL_OP_ERASE;
         2'b11: op = FEPL_OP_FLASH_WRITE;
         default: op = FEPL_OP_IDLE;
      endcase
   end

   // ==========================================
   // Pulse timer
   typedef enum logic [1:0] {
      FEPL_ST_IDLE,
      FEPL_ST_PULSE,
      FEPL_ST_WAIT_LOW
   } fepl_state_t;

   fepl_state_t state_q, state_d;
   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic start;
   logic refuse;
   logic finish;

   // Pulse start, refusal and end, shared by the groups below
   always_comb begin
      start = 1'b0;
      refuse = 1'b0;
      finish = 1'b0;
      if (state_q == FEPL_ST_IDLE && ctrl.execute_pulse_bit && op != FEPL_OP_IDLE) begin
         if (op == FEPL_OP_WRITE && ones > 5'(MAX_WRITE_BITS)) begin
            refuse = 1'b1; // guard against pump overload
         end else begin
            start = 1'b1;
         end
      end
      // Dropping the execute bit aborts the pulse early
      if (state_q == FEPL_ST_PULSE) begin
         if (cnt_q == CNT_RST || !ctrl.execute_pulse_bit) begin
            finish = 1'b1;
         end
      end
   end

   // Next state and pulse length count
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      case (state_q)
         FEPL_ST_IDLE: begin
            if (refuse) begin
               state_d = FEPL_ST_WAIT_LOW;
            end else if (start) begin
               state_d = FEPL_ST_PULSE;
               cnt_d = (op == FEPL_OP_ERASE) ? CNT_W'(ERASE_PULSE_CYC - 1)
                                             : CNT_W'(WRITE_PULSE_CYC - 1);
            end
         end
         FEPL_ST_PULSE: begin
            if (finish) begin
               state_d = FEPL_ST_WAIT_LOW;
            end else begin
               cnt_d = cnt_q - 24'h000001;
            end
         end
         FEPL_ST_WAIT_LOW: begin
            // A new pulse needs the execute bit lowered first
            if (!ctrl.execute_pulse_bit) begin
               state_d = FEPL_ST_IDLE;
            end
         end
         default: begin
            state_d = FEPL_ST_IDLE;
         end
      endcase
   end

   // Registers of the pulse timer
   always_ff @(posedge clock or negedge rst_s2_b) begin
      if (!rst_s2_b) begin
         state_q <= FEPL_ST_IDLE;
         cnt_q <= CNT_RST;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
      end
   end

   // ==========================================
   // Array drive
   fepl_array_t array_d;

   // Pump, mask and segments stand for the whole pulse
   always_comb begin
      array_d = array_o;
      // Margin reads pass to the array one cycle later, through its register, while idle
      if (state_q == FEPL_ST_IDLE) begin
         array_d.erase_margin_read = ctrl.erase_margin_read;
         array_d.program_margin_read = ctrl.program_margin_read;
      end
      if (start) begin
         array_d.erase_margin_read = 1'b0;
         array_d.program_margin_read = 1'b0;
         // Segment enables latched for the whole pulse
         array_d.seg_sel = ctrl.seg_en;
         array_d.pump_write = (op != FEPL_OP_ERASE);
         array_d.pump_erase = (op != FEPL_OP_WRITE);
         // Erase and flash-write move every bit of selected segments
         array_d.bit_mask = (op == FEPL_OP_WRITE) ? ~ctrl.wdata : 16'hFFFF;
      end
      if (finish) begin
         array_d.pump_write = 1'b0;
         array_d.pump_erase = 1'b0;
         array_d.bit_mask = MASK_RST;
      end
   end

   // Registers of the array drive
   always_ff @(posedge clock or negedge rst_s2_b) begin
      if (!rst_s2_b) begin
         array_o <= '{pump_write: 1'b0, pump_erase: 1'b0, erase_margin_read: 1'b0,
                      program_margin_read: 1'b0, seg_sel: SEG_RST, bit_mask: MASK_RST};
      end else begin
         array_o <= array_d;
      end
   end

   // ==========================================
   // Status flags
   logic busy_d;
   logic done_d;
   logic merr_d;

   // Busy rises with the pulse start and falls with its end
   always_comb begin
      busy_d = pulse_busy_q;
      if (start) begin
         busy_d = 1'b1;
      end
      if (finish) begin
         busy_d = 1'b0;
      end
   end

   // Register of the busy flag
   always_ff @(posedge clock or negedge rst_s2_b) begin
      if (!rst_s2_b) begin
         pulse_busy_q <= 1'b0;
      end else begin
         pulse_busy_q <= busy_d;
      end
   end

   // Done marks the end of a pulse for one cycle
   always_comb begin
      done_d = finish;
   end

   // Register of the done strobe
   always_ff @(posedge clock or negedge rst_s2_b) begin
      if (!rst_s2_b) begin
         pulse_done_q <= 1'b0;
      end else begin
         pulse_done_q <= done_d;
      end
   end

   // Sticky refusal flag; a refusal beats a clear in the same cycle
   always_comb begin
      merr_d = mask_error_q;
      if (mask_violation_ack) begin
         merr_d = 1'b0;
      end
      if (refuse) begin
         merr_d = 1'b1;
      end
   end

   // Register of the refusal flag
   always_ff @(posedge clock or negedge rst_s2_b) begin
      if (!rst_s2_b) begin
         mask_error_q <= 1'b0;
      end else begin
         mask_error_q <= merr_d;
      end
   end

endmodule : fepl_core

// [dv/fepl_props.sv]
`timescale 1ns/1ps
module fepl_props
   import fepl_pkg::*;
(
   input wire logic clock,
   input wire logic rst_b,
   input wire fepl_ctrl_t ctrl,
   input wire logic mask_violation_ack,
   input wire fepl_array_t array_o,
   input wire logic pulse_busy_q,
   input wire logic pulse_done_q,
   input wire logic mask_error_q
);
   // ==========================================
   // Pulse checks
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);
   wr_width_a: assert property (
      array_o.pump_write && !array_o.pump_erase |-> $countones(array_o.bit_mask) <= 8) else $error("write too wide");
   erase_all_a: assert property (
      array_o.pump_erase |-> array_o.bit_mask == 16'hFFFF) else $error("erase not on all bits");
   erase_cause_a: assert property (
      $rose(array_o.pump_erase) |-> $past(ctrl.erase_req)) else $error("erase pump without request");
   write_cause_a: assert property (
      $rose(array_o.pump_write) |-> $past(ctrl.write_req)) else $error("write pump without request");
   seg_hold_a: assert property (
      pulse_busy_q && $past(pulse_busy_q) |-> $stable(array_o.seg_sel)) else $error("segments moved");
   done_end_a: assert property (
      pulse_done_q |-> $fell(pulse_busy_q)) else $error("done without pulse end");
   refuse_a: assert property (
      $rose(mask_error_q) |-> !array_o.pump_write [*2]) else $error("refused write pulsed");
endmodule : fepl_props
bind fepl_core fepl_props fepl_props_i (.clock(clock), .rst_b(rst_b), .ctrl(ctrl),
   .mask_violation_ack(mask_violation_ack), .array_o(array_o), .pulse_busy_q(pulse_busy_q),
   .pulse_done_q(pulse_done_q), .mask_error_q(mask_error_q));

// [dv/fepl_array_model.sv]
`timescale 1ns/1ps
module fepl_array_model
   import fepl_pkg::*;
(
   input wire logic clock,
   input wire fepl_array_t array_i,
   output logic [WORD_W-1:0] cells
);
   // ==========================================
   // One cell word, starts erased; flash-write keeps it
   initial cells = 16'hFFFF;
   always @(posedge clock) begin
      if (array_i.pump_write && !array_i.pump_erase) begin
         cells <= cells & ~array_i.bit_mask;
      end else if (array_i.pump_erase && !array_i.pump_write) begin
         cells <= 16'hFFFF;
      end
   end
endmodule : fepl_array_model

// [dv/fepl_core_test.sv]
`timescale 1ns/1ps
module fepl_core_test;
   import fepl_pkg::*;
   logic clock;
   logic rst_b;
   logic ack;
   logic busy;
   logic done;
   logic merr;
   fepl_ctrl_t c;
   fepl_array_t arr;
   logic [WORD_W-1:0] cells;
   int error_cnt = 0;
   int checked = 0;
   fepl_core fepl_core_i (.clock(clock), .rst_b(rst_b), .ctrl(c), .mask_violation_ack(ack), .array_o(arr),
      .pulse_busy_q(busy), .pulse_done_q(done), .mask_error_q(merr));
   fepl_array_model fepl_array_model_i (.clock(clock), .array_i(arr), .cells(cells));
   // ==========================================
   // Clock, watchdog and helpers
   initial begin
      clock = 0;
      forever #25 clock = ~clock;
   end
   initial begin
      #(8000 * 50);
      error_cnt++;
      finish_test();
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic finish_test;
      $display("errors %0d checks %0d", error_cnt, checked);
      if (error_cnt == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : finish_test
   task automatic go(input logic w, input logic e, input logic [7:0] s, input logic [15:0] d);
      @(posedge clock);
      c <= {w, e, 1'b1, 2'b00, s, d};
      repeat (3) @(posedge clock);
      #1;
   endtask : go
   task automatic stop;
      @(posedge clock);
      c <= '0;
      for (int i = 0; i < 10 && busy !== 1'b0; i++) @(posedge clock);
      repeat (2) @(posedge clock);
      #1;
      chk(busy, 0);
   endtask : stop
   // ==========================================
   // Scenarios
   task automatic mread(input logic er, input logic pr, input logic [15:0] exp);
      @(posedge clock);
      c.erase_margin_read <= er;
      c.program_margin_read <= pr;
      repeat (3) @(posedge clock);
      #1;
      chk({arr.erase_margin_read, arr.program_margin_read}, {er, pr});
      chk(cells, exp);
      @(posedge clock);
      c.erase_margin_read <= 1'b0;
      c.program_margin_read <= 1'b0;
   endtask : mread
   task automatic t_write;
      int n;
      n = 0;
      go(1, 0, 8'h01, 16'hFF00);
      chk(arr.bit_mask, 16'h00FF);
      chk({arr.pump_write, arr.pump_erase}, 2'b10);
      while (n < 2100 && done !== 1'b1) begin
         @(posedge clock) #1;
         n++;
      end
      chk(done, 1);
      chk(16'(n), 16'(WRITE_PULSE_CYC - 2));
      chk(cells, 16'hFF00);
      stop();
   endtask : t_write
   task automatic t_refuse;
      go(1, 0, 8'h01, 16'h7F00);
      chk({merr, busy}, 2'b10);
      stop();
      @(posedge clock);
      ack <= 1;
      @(posedge clock);
      ack <= 0;
      @(posedge clock) #1;
      chk(merr, 0);
   endtask : t_refuse
   task automatic t_erase(input logic w, input logic [7:0] s);
      go(w, 1, s, 16'hFFFF);
      chk({arr.pump_write, arr.pump_erase}, {w, 1'b1});
      chk(arr.bit_mask, 16'hFFFF);
      chk(arr.seg_sel, s);
      stop();
      chk(cells, 16'hFFFF);
   endtask : t_erase
   task automatic t_flow;
      go(1, 0, 8'h01, 16'hFF00);
      stop();
      go(1, 0, 8'h01, 16'h00FF);
      stop();
      mread(0, 1, 16'h0000);
      go(0, 1, 8'h01, 16'hFFFF);
      stop();
      mread(1, 0, 16'hFFFF);
      go(1, 1, 8'h01, 16'hFFFF);
      stop();
      mread(1, 0, 16'hFFFF);
      go(1, 0, 8'h01, 16'h0FF0);
      stop();
      mread(0, 1, 16'h0FF0);
      go(1, 0, 8'h02, 16'h0FF0);
      stop();
      mread(0, 1, 16'h0FF0);
      chk(merr, 0);
   endtask : t_flow
   initial begin
      rst_b = 0;
      c = '0;
      ack = 0;
      repeat (12) @(posedge clock);
      rst_b <= 1;
      repeat (3) @(posedge clock);
      mread(1, 0, 16'hFFFF);
      t_write();
      t_refuse();
      t_erase(0, 8'h05);
      t_erase(1, 8'h06);
      t_flow();
      finish_test();
   end
endmodule : fepl_core_test
